// ===== pkg/lc_pkg.sv
package lc_pkg;

	// ----------------------------------------------------------------
	// widths and depths
	// ----------------------------------------------------------------
	localparam int DW        = 8;   // datapath and register width
	localparam int ARRAYS    = 2;   // logic arrays per cell
	localparam int PT_IN     = 12;  // inputs per logic array
	localparam int PT_NUM    = 8;   // product terms per array
	localparam int PT_OUT    = 4;   // outputs per array
	localparam int QUEUES    = 2;   // byte queues per datapath
	localparam int Q_DEPTH   = 4;   // bytes per queue
	localparam int Q_PW      = 2;   // queue pointer width
	localparam int Q_CW      = 3;   // queue count width
	localparam int RB_DEPTH  = 2;   // read return buffer entries

	// ----------------------------------------------------------------
	// system bus byte addresses
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_ACC0 = 3'h0;
	localparam logic [2:0] ADDR_ACC1 = 3'h1;
	localparam logic [2:0] ADDR_OPR0 = 3'h2;
	localparam logic [2:0] ADDR_OPR1 = 3'h3;
	localparam logic [2:0] ADDR_BQ0  = 3'h4;
	localparam logic [2:0] ADDR_BQ1  = 3'h5;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [DW-1:0] REG_RST = 8'h00;
	localparam logic [DW-1:0] RD_NONE = 8'h00;  // unmapped or empty read

	// ----------------------------------------------------------------
	// datapath encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_PASS = 3'h0,
		OP_INC  = 3'h1,
		OP_DEC  = 3'h2,
		OP_ADD  = 3'h3,
		OP_SUB  = 3'h4,
		OP_AND  = 3'h5,
		OP_OR   = 3'h6,
		OP_XOR  = 3'h7
	} lc_op_t;

	// working register index: accumulators 0/1, operand registers 2/3
	localparam logic [1:0] WR_ACC0 = 2'h0;
	localparam logic [1:0] WR_ACC1 = 2'h1;
	localparam logic [1:0] WR_OPR0 = 2'h2;
	localparam logic [1:0] WR_OPR1 = 2'h3;

	// queue capture source in output mode
	localparam logic [1:0] QS_ACC0 = 2'h0;
	localparam logic [1:0] QS_ACC1 = 2'h1;
	localparam logic [1:0] QS_ALU  = 2'h2;

	// queue direction
	localparam logic QM_IN  = 1'b0;  // bus writes, datapath reads
	localparam logic QM_OUT = 1'b1;  // datapath writes, bus reads

endpackage

// ===== hdl/lc_logic_cell.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] two independent sum-of-products arrays fed from the routing fabric
// [R2] each array takes twelve inputs shared by eight product terms
// [R3] product term ANDs one to twelve inputs, each true or complemented
// [R4] each output ORs up to eight terms; OR width fixed at eight
// [R5] each array output selectable as combinational or registered
// [R6] eight-bit single-cycle ALU with compare and condition logic
// [R7] four working registers reachable by firmware or DMA over the bus
// [R8] accumulators are ALU sources and sinks and compare sources
// [R9] operand registers are ALU and compare sources only, never ALU sinks
// [R10] two byte queues, four bytes deep, between bus and datapath
// [R11] queue loads operand/accumulator registers or captures accumulator/ALU
// [R12] each queue independently an input or an output buffer
// [R13] all registers and queue entries one byte; one byte per bus access
module lc_logic_cell
	import lc_pkg::*;
(
	// clock and reset
	input  wire logic                             MCLK,
	input  wire logic                             RST_N,
	// logic arrays: routing inputs and configuration
	input  wire logic [ARRAYS*PT_IN-1:0]          PLD_IN,
	input  wire logic [ARRAYS*PT_NUM*PT_IN-1:0]   PLD_TRUE_SEL,
	input  wire logic [ARRAYS*PT_NUM*PT_IN-1:0]   PLD_COMP_SEL,
	input  wire logic [ARRAYS*PT_OUT*PT_NUM-1:0]  PLD_OR_SEL,
	input  wire logic [ARRAYS*PT_OUT-1:0]         PLD_REG_SEL,
	output logic      [ARRAYS*PT_OUT-1:0]         PLD_OUT,
	// datapath control from the routing fabric
	input  wire logic                             DP_EXEC,
	input  wire logic [2:0]                       DP_OP,
	input  wire logic                             DP_SRCA,
	input  wire logic [1:0]                       DP_SRCB,
	input  wire logic                             DP_DST,
	input  wire logic [QUEUES-1:0]                DP_Q_MODE,
	input  wire logic [QUEUES-1:0]                DP_Q_LOAD,
	input  wire logic [QUEUES*2-1:0]              DP_Q_LOAD_DST,
	input  wire logic [QUEUES-1:0]                DP_Q_CAPT,
	input  wire logic [QUEUES*2-1:0]              DP_Q_CAPT_SRC,
	// datapath conditions
	output logic      [DW-1:0]                    DP_ALU_OUT,
	output logic      [1:0]                       DP_CMP_EQ,
	output logic      [1:0]                       DP_CMP_LT,
	output logic                                  DP_ZERO,
	output logic                                  DP_ONES,
	output logic      [QUEUES-1:0]                DP_Q_EMPTY,
	output logic      [QUEUES-1:0]                DP_Q_FULL,
	// system bus byte port
	input  wire logic [2:0]                       BUS_ADDR,
	input  wire logic                             BUS_WR,
	input  wire logic [DW-1:0]                    BUS_WDATA,
	input  wire logic                             BUS_RD,
	output logic                                  BUS_RD_READY,
	output logic                                  BUS_RVALID,
	input  wire logic                             BUS_RREADY,
	output logic      [DW-1:0]                    BUS_RDATA
);

	// ----------------------------------------------------------------
	// logic arrays
	// ----------------------------------------------------------------
	logic [ARRAYS*PT_OUT-1:0] pld_comb;
	logic [ARRAYS*PT_OUT-1:0] pld_q_r;

	genvar ga, gt, go;
	generate
		for (ga = 0; ga < ARRAYS; ga++) begin : g_arr  // see [R1]
			logic [PT_IN-1:0]  in_v;
			logic [PT_NUM-1:0] pterm;
			assign in_v = PLD_IN[ga*PT_IN +: PT_IN];  // see [R2]
			for (gt = 0; gt < PT_NUM; gt++) begin : g_term
				logic [PT_IN-1:0] tsel;
				logic [PT_IN-1:0] csel;
				assign tsel = PLD_TRUE_SEL[(ga*PT_NUM+gt)*PT_IN +: PT_IN];
				assign csel = PLD_COMP_SEL[(ga*PT_NUM+gt)*PT_IN +: PT_IN];
				// a term with no input selected stays low instead of always true
				assign pterm[gt] = (|(tsel | csel)) &
					(&((~tsel | in_v) & (~csel | ~in_v)));  // see [R3]
			end
			for (go = 0; go < PT_OUT; go++) begin : g_out
				// every output sees all eight terms
				assign pld_comb[ga*PT_OUT+go] =
					|(pterm & PLD_OR_SEL[(ga*PT_OUT+go)*PT_NUM +: PT_NUM]);  // see [R4]
			end
		end
	endgenerate

	// registered copy of every array output
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			pld_q_r <= '0;
		end else begin
			pld_q_r <= pld_comb;  // see [R5]
		end
	end

	// combinational mode bypasses the flop by design
	assign PLD_OUT = (PLD_REG_SEL & pld_q_r) | (~PLD_REG_SEL & pld_comb);  // see [R5]

	// ----------------------------------------------------------------
	// ALU
	// ----------------------------------------------------------------
	logic [DW-1:0] wreg_r [4];
	logic [DW-1:0] opa;
	logic [DW-1:0] opb;
	logic [DW-1:0] alu_res;

	assign opa = DP_SRCA ? wreg_r[WR_ACC1] : wreg_r[WR_ACC0];  // see [R8]
	assign opb = wreg_r[DP_SRCB];  // see [R9]

	// single-cycle result, written back on the same edge
	always_comb begin
		unique case (lc_op_t'(DP_OP))  // see [R6]
			OP_PASS: alu_res = opa;
			OP_INC:  alu_res = opa + 8'h01;
			OP_DEC:  alu_res = opa - 8'h01;
			OP_ADD:  alu_res = opa + opb;
			OP_SUB:  alu_res = opa - opb;
			OP_AND:  alu_res = opa & opb;
			OP_OR:   alu_res = opa | opb;
			OP_XOR:  alu_res = opa ^ opb;
		endcase
	end

	// compare and condition flags
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			DP_ALU_OUT <= REG_RST;
			DP_CMP_EQ  <= 2'h0;
			DP_CMP_LT  <= 2'h0;
			DP_ZERO    <= 1'b0;
			DP_ONES    <= 1'b0;
		end else begin
			DP_ALU_OUT <= alu_res;
			DP_CMP_EQ  <= {wreg_r[WR_ACC1] == wreg_r[WR_OPR1],
			               wreg_r[WR_ACC0] == wreg_r[WR_OPR0]};  // see [R6]
			DP_CMP_LT  <= {wreg_r[WR_ACC1] <  wreg_r[WR_OPR1],
			               wreg_r[WR_ACC0] <  wreg_r[WR_OPR0]};  // see [R8] [R9]
			DP_ZERO    <= alu_res == 8'h00;
			DP_ONES    <= alu_res == 8'hFF;
		end
	end

	// ----------------------------------------------------------------
	// byte queues
	// ----------------------------------------------------------------
	logic [DW-1:0]     q_mem_r  [QUEUES][Q_DEPTH];
	logic [Q_PW-1:0]   q_wp_r   [QUEUES];
	logic [Q_PW-1:0]   q_rp_r   [QUEUES];
	logic [Q_CW-1:0]   q_cnt_r  [QUEUES];
	logic [DW-1:0]     q_head   [QUEUES];
	logic [QUEUES-1:0] q_push;
	logic [QUEUES-1:0] q_pop;
	logic [DW-1:0]     q_wdata  [QUEUES];
	logic              rd_take;

	genvar gq;
	generate
		for (gq = 0; gq < QUEUES; gq++) begin : g_q  // see [R10]
			logic mode_out;
			logic empty;
			logic full;
			logic bus_hit;
			logic [1:0] csrc;
			assign mode_out = DP_Q_MODE[gq];  // see [R12]
			assign empty    = q_cnt_r[gq] == 3'h0;
			assign full     = q_cnt_r[gq] == 3'(Q_DEPTH);
			assign bus_hit  = BUS_ADDR == (ADDR_BQ0 + 3'(gq));
			assign csrc     = DP_Q_CAPT_SRC[gq*2 +: 2];
			assign q_head[gq] = q_mem_r[gq][q_rp_r[gq]];
			// pushes and pops on a full or empty queue are dropped
			assign q_push[gq] = !full & (mode_out ? DP_Q_CAPT[gq]
			                                      : (BUS_WR & bus_hit));  // see [R12]
			assign q_pop[gq]  = !empty & (mode_out ? (rd_take & bus_hit)
			                                       : DP_Q_LOAD[gq]);
			// capture from an accumulator or the ALU result
			assign q_wdata[gq] = !mode_out ? BUS_WDATA :
				(csrc == QS_ALU)  ? alu_res :
				(csrc == QS_ACC1) ? wreg_r[WR_ACC1] : wreg_r[WR_ACC0];  // see [R11]

			// queue storage and pointers
			always_ff @(posedge MCLK) begin
				if (!RST_N) begin
					q_wp_r[gq]  <= '0;
					q_rp_r[gq]  <= '0;
					q_cnt_r[gq] <= '0;
				end else begin
					if (q_push[gq]) begin
						q_mem_r[gq][q_wp_r[gq]] <= q_wdata[gq];  // see [R13]
						q_wp_r[gq] <= q_wp_r[gq] + 2'h1;
					end
					if (q_pop[gq]) begin
						q_rp_r[gq] <= q_rp_r[gq] + 2'h1;
					end
					q_cnt_r[gq] <= q_cnt_r[gq] + 3'(q_push[gq]) - 3'(q_pop[gq]);
				end
			end

			// status flags registered for the fabric
			always_ff @(posedge MCLK) begin
				if (!RST_N) begin
					DP_Q_EMPTY[gq] <= 1'b1;
					DP_Q_FULL[gq]  <= 1'b0;
				end else begin
					DP_Q_EMPTY[gq] <= (q_cnt_r[gq] + 3'(q_push[gq]) - 3'(q_pop[gq])) == 3'h0;
					DP_Q_FULL[gq]  <= (q_cnt_r[gq] + 3'(q_push[gq]) - 3'(q_pop[gq]))
					                  == 3'(Q_DEPTH);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// working registers
	// ----------------------------------------------------------------
	// priority: bus write, then queue 1 load, queue 0 load, then ALU sink
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			for (int i = 0; i < 4; i++) begin
				wreg_r[i] <= REG_RST;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (BUS_WR && BUS_ADDR == 3'(i)) begin
					wreg_r[i] <= BUS_WDATA;  // see [R7] [R13]
				end else if (q_pop[1] && !DP_Q_MODE[1] && DP_Q_LOAD_DST[3:2] == 2'(i)) begin
					wreg_r[i] <= q_head[1];  // see [R11]
				end else if (q_pop[0] && !DP_Q_MODE[0] && DP_Q_LOAD_DST[1:0] == 2'(i)) begin
					wreg_r[i] <= q_head[0];  // see [R11]
				end else if (DP_EXEC && i < 2 && DP_DST == i[0]) begin
					wreg_r[i] <= alu_res;  // see [R8] [R9]
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// bus read return buffer
	// ----------------------------------------------------------------
	logic [DW-1:0] rd_sel;
	logic [DW-1:0] rb_r [RB_DEPTH];
	logic [1:0]    rb_cnt_r;
	logic [1:0]    rb_cnt_nxt;
	logic          rb_drain;

	// read of an empty queue or an unmapped address returns zero
	always_comb begin
		unique case (BUS_ADDR)
			ADDR_ACC0, ADDR_ACC1, ADDR_OPR0, ADDR_OPR1: rd_sel = wreg_r[BUS_ADDR[1:0]];
			ADDR_BQ0: rd_sel = q_cnt_r[0] != 3'h0 ? q_head[0] : RD_NONE;
			ADDR_BQ1: rd_sel = q_cnt_r[1] != 3'h0 ? q_head[1] : RD_NONE;
			default:  rd_sel = RD_NONE;
		endcase
	end

	// ready is registered from the next count, so it does not lag and never overfills
	assign rd_take    = BUS_RD & BUS_RD_READY;
	assign rb_drain   = BUS_RVALID & BUS_RREADY;
	assign rb_cnt_nxt = rb_cnt_r + 2'(rd_take) - 2'(rb_drain);

	// two entries: head drives the port, second absorbs a stall
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			rb_cnt_r     <= 2'h0;
			rb_r[0]      <= RD_NONE;
			rb_r[1]      <= RD_NONE;
			BUS_RD_READY <= 1'b1;
			BUS_RVALID   <= 1'b0;
			BUS_RDATA    <= RD_NONE;
		end else begin
			rb_cnt_r     <= rb_cnt_nxt;
			BUS_RD_READY <= rb_cnt_nxt < 2'(RB_DEPTH);
			BUS_RVALID   <= rb_cnt_nxt != 2'h0;
			if (rb_drain) begin
				rb_r[0] <= (rd_take && rb_cnt_r == 2'h1) ? rd_sel : rb_r[1];
			end else if (rd_take && rb_cnt_r == 2'h0) begin
				rb_r[0] <= rd_sel;
			end
			if (rd_take && rb_cnt_nxt == 2'h2) begin
				rb_r[1] <= rd_sel;
			end
			if (rb_drain) begin
				BUS_RDATA <= (rd_take && rb_cnt_r == 2'h1) ? rd_sel : rb_r[1];
			end else if (rd_take && rb_cnt_r == 2'h0) begin
				BUS_RDATA <= rd_sel;  // see [R13]
			end
		end
	end

endmodule

// ===== verif/lc_logic_cell_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// port-level properties of the logic cell
// ----------------------------------------
module lc_logic_cell_properties
	import lc_pkg::*;
(
	// clock and reset
	input wire logic       MCLK,
	input wire logic       RST_N,
	// datapath
	input wire logic       DP_EXEC,
	input wire logic [2:0] DP_OP,
	input wire logic       DP_SRCA,
	input wire logic       DP_DST,
	input wire logic [1:0] DP_Q_MODE,
	input wire logic [1:0] DP_Q_LOAD,
	input wire logic [7:0] DP_ALU_OUT,
	input wire logic       DP_ZERO,
	input wire logic       DP_ONES,
	input wire logic [1:0] DP_Q_EMPTY,
	input wire logic [1:0] DP_Q_FULL,
	// system bus
	input wire logic [2:0] BUS_ADDR,
	input wire logic       BUS_WR,
	input wire logic       BUS_RD,
	input wire logic       BUS_RD_READY,
	input wire logic       BUS_RVALID,
	input wire logic       BUS_RREADY,
	input wire logic [7:0] BUS_RDATA
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// increment of acc0 with no bus write or queue load competing
	sequence inc_acc0;
		DP_EXEC && DP_OP == 3'h1 && !DP_SRCA && !DP_DST && DP_Q_LOAD == 2'b00 &&
			!(BUS_WR && BUS_ADDR == ADDR_ACC0);
	endsequence
	// bus byte aimed at queue zero while it is an input buffer
	sequence push_q0;
		BUS_WR && BUS_ADDR == ADDR_BQ0 && DP_Q_MODE[0] == QM_IN && !DP_Q_LOAD[0];
	endsequence
	a_alu_inc: assert property (inc_acc0 ##1 inc_acc0 |=>
		DP_ALU_OUT == $past(DP_ALU_OUT) + 8'h01) else $error("alu increment chain wrong");
	a_zero_flag: assert property ($past(RST_N) |-> DP_ZERO == (DP_ALU_OUT == 8'h00))
		else $error("zero flag disagrees with alu result");
	a_ones_flag: assert property ($past(RST_N) |-> DP_ONES == (DP_ALU_OUT == 8'hFF))
		else $error("ones flag disagrees with alu result");
	a_push_fills: assert property (push_q0 and DP_Q_EMPTY[0] |=> !DP_Q_EMPTY[0])
		else $error("queue push lost");
	a_full_holds: assert property (push_q0 and DP_Q_FULL[0] |=> DP_Q_FULL[0])
		else $error("full queue lost an entry");
	a_flags_excl: assert property ((DP_Q_EMPTY & DP_Q_FULL) == 2'b00)
		else $error("queue empty and full together");
	a_read_answer: assert property (BUS_RD && BUS_RD_READY && !BUS_RVALID |=> BUS_RVALID)
		else $error("read not answered in one cycle");
	a_rdata_hold: assert property (BUS_RVALID && !BUS_RREADY |=>
		BUS_RVALID && $stable(BUS_RDATA)) else $error("read data dropped before accept");
endmodule

bind lc_logic_cell lc_logic_cell_properties u_lc_logic_cell_properties (.MCLK, .RST_N,
	.DP_EXEC, .DP_OP, .DP_SRCA, .DP_DST, .DP_Q_MODE, .DP_Q_LOAD, .DP_ALU_OUT, .DP_ZERO,
	.DP_ONES, .DP_Q_EMPTY, .DP_Q_FULL, .BUS_ADDR, .BUS_WR, .BUS_RD, .BUS_RD_READY,
	.BUS_RVALID, .BUS_RREADY, .BUS_RDATA);

// ===== verif/lc_bus_sink.sv
`timescale 1ns/1ps
// ----------------------------------------
// read-return consumer on the system bus
// ----------------------------------------
module lc_bus_sink (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// read return handshake
	input  wire logic rvalid,
	output logic      rready
);
	// random stalls so the return buffer backs up and refuses
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rready <= 1'b0;
		end else begin
			rready <= rvalid && (($urandom % 3) == 0);
		end
	end
endmodule

// ===== verif/lc_logic_cell_bench.sv
`timescale 1ns/1ps
module lc_logic_cell_bench
	import lc_pkg::*;
;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic mclk = 0, rst_n = 0, bus_wr = 0, bus_rd = 0, dp_exec = 0, dp_srca = 0, dp_dst = 0;
	logic [23:0]  pld_in = '0;
	logic [191:0] t_sel = '0, c_sel = '0;
	logic [63:0]  or_sel = '0;
	logic [7:0]   reg_sel = '0, bus_wdata = '0, pld_out, alu_out, rdata, a, b, v;
	logic [2:0]   dp_op = '0, bus_addr = '0;
	logic [1:0]   dp_srcb = '0, q_mode = '0, q_load = '0, q_capt = '0;
	logic [1:0]   cmp_eq, cmp_lt, q_empty, q_full;
	logic [3:0]   load_dst = '0, capt_src = '0;
	logic         zero, ones, rd_ready, rvalid, rready, e = 0, eo;
	logic [7:0]   exp_q[$];
	int           num_errors = 0, check_count = 0;

	lc_logic_cell u_lc_logic_cell (.MCLK(mclk), .RST_N(rst_n), .PLD_IN(pld_in),
		.PLD_TRUE_SEL(t_sel), .PLD_COMP_SEL(c_sel), .PLD_OR_SEL(or_sel),
		.PLD_REG_SEL(reg_sel), .PLD_OUT(pld_out), .DP_EXEC(dp_exec), .DP_OP(dp_op),
		.DP_SRCA(dp_srca), .DP_SRCB(dp_srcb), .DP_DST(dp_dst), .DP_Q_MODE(q_mode),
		.DP_Q_LOAD(q_load), .DP_Q_LOAD_DST(load_dst), .DP_Q_CAPT(q_capt),
		.DP_Q_CAPT_SRC(capt_src), .DP_ALU_OUT(alu_out), .DP_CMP_EQ(cmp_eq),
		.DP_CMP_LT(cmp_lt), .DP_ZERO(zero), .DP_ONES(ones), .DP_Q_EMPTY(q_empty),
		.DP_Q_FULL(q_full), .BUS_ADDR(bus_addr), .BUS_WR(bus_wr), .BUS_WDATA(bus_wdata),
		.BUS_RD(bus_rd), .BUS_RD_READY(rd_ready), .BUS_RVALID(rvalid),
		.BUS_RREADY(rready), .BUS_RDATA(rdata));
	lc_bus_sink u_lc_bus_sink (.clk(mclk), .rst_n(rst_n), .rvalid(rvalid), .rready(rready));

	// 100 MHz clock
	always #5 mclk = ~mclk;

	task chk(input string nm, input logic [7:0] ex, input logic [7:0] seen);
		check_count++;
		if (seen !== ex) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	task summarize;
		$display("checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one write strobe, held through the taking edge
	task wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge mclk);
		bus_wr <= 1'b1;
		bus_addr <= ad;
		bus_wdata <= d;
		@(posedge mclk);
		bus_wr <= 1'b0;
	endtask

	// read request held until ready is sampled; expectation noted at the take
	task rd(input logic [2:0] ad, input logic [7:0] ex);
		int n;
		n = 0;
		@(posedge mclk);
		bus_rd <= 1'b1;
		bus_addr <= ad;
		do begin
			@(posedge mclk);
			n++;
		end while (rd_ready !== 1'b1 && n < 50);
		exp_q.push_back(ex);
		bus_rd <= 1'b0;
		if (rd_ready !== 1'b1) begin
			num_errors++;
			summarize();
		end
	endtask

	task ex(input logic [2:0] op, input logic [1:0] sb, input logic d, input int n);
		@(posedge mclk);
		dp_exec <= 1'b1;
		dp_op <= op;
		dp_srcb <= sb;
		dp_dst <= d;
		repeat (n) @(posedge mclk);
		dp_exec <= 1'b0;
	endtask

	function automatic logic [7:0] alu(input logic [2:0] op, input logic [7:0] x, y);
		logic [7:0] r [8];
		r = '{x, x + 8'h01, x - 8'h01, x + y, x - y, x & y, x | y, x ^ y};
		return r[op];
	endfunction

	// returned bytes are matched against the oldest note
	always @(posedge mclk) begin
		if (rst_n && rvalid === 1'b1 && rready === 1'b1) begin
			chk("bus rdata", exp_q.size() > 0 ? exp_q[0] : 8'hXX, rdata);
			if (exp_q.size() > 0)
				void'(exp_q.pop_front());
		end
	end

	initial begin
		void'($urandom(892));
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1;
		chk("reset flags", 8'h32, {2'h0, q_empty, q_full, rd_ready, rvalid});
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wr(i[2:0], v);
			rd(i[2:0], v);
		end
		rd(3'h6, RD_NONE);
		$display("test registers done");
		for (int i = 0; i < 5; i++) wr(ADDR_BQ0, 8'h10 + i[7:0]);
		#1;
		chk("queue0 full", 8'h01, {7'h0, q_full[0]});
		rd(ADDR_BQ0, 8'h10);
		@(posedge mclk);
		q_load <= 2'b01;
		load_dst <= {2'b00, WR_OPR0};
		repeat (5) @(posedge mclk);
		q_load <= 2'b00;
		#1;
		chk("queue0 empty", 8'h01, {7'h0, q_empty[0]});
		rd(ADDR_OPR0, 8'h13);
		$display("test input queue done");
		a = 8'($urandom);
		wr(ADDR_ACC0, a);
		@(posedge mclk);
		q_mode <= 2'b10;
		q_capt <= 2'b10;
		capt_src <= {QS_ACC0, 2'b00};
		dp_op <= OP_INC;
		@(posedge mclk);
		capt_src <= {QS_ALU, 2'b00};
		@(posedge mclk);
		q_capt <= 2'b00;
		wr(ADDR_BQ1, 8'hEE);
		rd(ADDR_BQ1, a);
		rd(ADDR_BQ1, a + 8'h01);
		rd(ADDR_BQ1, RD_NONE);
		$display("test output queue done");
		// xor with the complement and a self-subtract reach both flags
		for (int op = 0; op < 8; op++) begin
			a = 8'($urandom);
			b = (op == 7) ? ~a : (op == 4) ? a : 8'($urandom);
			wr(ADDR_ACC0, a);
			wr(ADDR_OPR1, b);
			ex(op[2:0], 2'h3, 1'b1, 1);
			#1;
			v = alu(op[2:0], a, b);
			chk("alu out", v, alu_out);
			chk("alu flags", {6'h0, v == 8'hFF, v == 8'h00}, {6'h0, ones, zero});
			rd(ADDR_ACC1, v);
		end
		rd(ADDR_OPR1, b);
		wr(ADDR_ACC0, a);
		ex(OP_INC, 2'h0, 1'b0, 3);
		rd(ADDR_ACC0, a + 8'h03);
		// accumulator one as the A operand, result into accumulator zero
		dp_srca <= 1'b1;
		wr(ADDR_ACC1, b);
		ex(OP_DEC, 2'h0, 1'b0, 1);
		dp_srca <= 1'b0;
		rd(ADDR_ACC0, b - 8'h01);
		// both compare pairs; a stays below FF so a+1 cannot wrap
		a = 8'($urandom % 255);
		wr(ADDR_ACC0, a);
		wr(ADDR_OPR0, a);
		wr(ADDR_ACC1, a + 8'h01);
		wr(ADDR_OPR1, a);
		repeat (2) @(posedge mclk);
		#1;
		chk("compare eq", 8'h01, {4'h0, cmp_lt[1], cmp_eq[1], cmp_lt[0], cmp_eq[0]});
		wr(ADDR_OPR0, a + 8'h01);
		wr(ADDR_OPR1, a + 8'h01);
		repeat (2) @(posedge mclk);
		#1;
		chk("compare lt", 8'h06, {4'h0, cmp_lt[1], cmp_eq[1], cmp_lt[0], cmp_eq[0]});
		$display("test alu and compare done");
		@(posedge mclk);
		t_sel[10:0] <= 11'h7FF;
		c_sel[11] <= 1'b1;
		t_sel[23] <= 1'b1;
		c_sel[96] <= 1'b1;
		or_sel <= 64'h0000_0001_0000_0303;
		reg_sel <= 8'h02;
		@(posedge mclk);
		for (int i = 0; i < 24; i++) begin
			@(posedge mclk);
			pld_in <= (i < 2) ? {11'h0, i[0], 12'h7FF} : 24'($urandom);
			#1;
			eo = e;
			e = &pld_in[10:0] | pld_in[11];
			chk("pld comb", {7'h0, e}, {7'h0, pld_out[0]});
			chk("pld reg hold", {7'h0, eo}, {7'h0, pld_out[1]});
			@(posedge mclk);
			#1;
			chk("pld outs", {3'h0, ~pld_in[12], 2'h0, e, e}, pld_out);
		end
		$display("test logic arrays done");
		repeat (200) if (exp_q.size() > 0) @(posedge mclk);
		if (exp_q.size() > 0)
			num_errors++;
		summarize();
	end
endmodule
